/* hw/imuaux_outputs.sv */
// Temperature, time stamp, update counter and delta angle output registers
`timescale 1ns/1ps
module imuaux_outputs
#(
    parameter int STAMP_CYCLES = imuaux_pkg::STAMP_LSB_CYCLES,
    parameter imuaux_pkg::imuaux_range_type RANGE_SEL = imuaux_pkg::RANGE_SEL_360
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sampleStrobe,
    input wire logic [15:0] tempRaw,
    input wire logic [95:0] gyroRate,
    input wire logic syncPin,
    input wire logic [15:0] miscControl,
    input wire logic [15:0] decimationDivisor,
    input wire logic regRd,
    input wire logic regWr,
    input wire logic [6:0] regAddr,
    output logic [15:0] regRdData,
    output logic regAck,
    output logic dataUpdate
);

    logic [15:0] sampleCount_q, sampleCount_d;
    logic lastSample;
    logic [15:0] temp_q, temp_d;
    logic [15:0] stamp_q, stamp_d;
    logic [15:0] count_q, count_d;
    logic [31:0] prescale_q, prescale_d;
    logic [15:0] elapsed_q, elapsed_d;
    logic syncPrev_q;
    logic syncEdge;
    logic scaledMode;
    logic update_q;
    logic [15:0] rdData_q, rdData_d;
    logic ack_q;
    logic [31:0] angle [imuaux_pkg::AXES];
    logic [63:0] gainSel;

    // Gain chosen once per build by range variant
    always_comb
    begin
        case (RANGE_SEL)
            imuaux_pkg::RANGE_SEL_360: gainSel = 64'(imuaux_pkg::GAIN_360);
            imuaux_pkg::RANGE_SEL_720: gainSel = 64'(imuaux_pkg::GAIN_720);
            imuaux_pkg::RANGE_SEL_2160: gainSel = 64'(imuaux_pkg::GAIN_2160);
            default: gainSel = 64'(imuaux_pkg::GAIN_360);
        endcase
    end

    // Final sample of a decimation period: divisor plus one samples
    assign lastSample = sampleStrobe && (sampleCount_q == decimationDivisor);

    always_comb
    begin
        sampleCount_d = sampleCount_q;
        if (sampleStrobe)
        begin
            if (lastSample)
            begin
                sampleCount_d = 16'h0000;
            end
            else
            begin
                sampleCount_d = sampleCount_q + 16'h0001;
            end
        end
    end

    // One integrator per axis
    genvar ax;
    generate
        for (ax = 0; ax < imuaux_pkg::AXES; ax++)
        begin : g_axis
            imuaux_axis_if axisBus();
            assign axisBus.sampleValid = sampleStrobe;
            assign axisBus.lastSample = lastSample;
            assign axisBus.rateIn = gyroRate[ax*32 +: 32];
            assign axisBus.gain = gainSel;
            assign angle[ax] = axisBus.angleOut;
            imuaux_integrator u_integ
            (
                .clk(clk),
                .rst_n(rst_n),
                .axis(axisBus.integ)
            );
        end
    endgenerate

    // Sync edge and scaled mode decode
    assign syncEdge = syncPin && !syncPrev_q;
    assign scaledMode = miscControl[imuaux_pkg::SYNC_MODE_MSB:imuaux_pkg::SYNC_MODE_LSB]
        == imuaux_pkg::SYNC_MODE_SCALED;

    // Elapsed time since last sync edge; saturates rather than wraps
    always_comb
    begin
        prescale_d = prescale_q;
        elapsed_d = elapsed_q;
        if (syncEdge)
        begin
            prescale_d = 32'h0000_0000;
            elapsed_d = 16'h0000;
        end
        else if (prescale_q == 32'(STAMP_CYCLES - 1))
        begin
            prescale_d = 32'h0000_0000;
            if (elapsed_q != imuaux_pkg::COUNT_MAX)
            begin
                elapsed_d = elapsed_q + 16'h0001;
            end
        end
        else
        begin
            prescale_d = prescale_q + 32'h0000_0001;
        end
    end

    // Output register loads on each update
    always_comb
    begin
        temp_d = temp_q;
        stamp_d = stamp_q;
        count_d = count_q;
        if (lastSample)
        begin
            temp_d = tempRaw;
            // Outside scaled sync mode the stamp carries no meaning, so it reads zero
            stamp_d = scaledMode ? elapsed_q : imuaux_pkg::WORD_ZERO;
            count_d = count_q + 16'h0001;
        end
    end

    // Register read mux; writes are acknowledged but never stored
    always_comb
    begin
        rdData_d = rdData_q;
        if (regRd && !regWr)
        begin
            rdData_d = imuaux_pkg::WORD_ZERO;
            case (regAddr)
                imuaux_pkg::OFS_DIE_HEAT: rdData_d = temp_q;
                imuaux_pkg::OFS_SYNC_ELAPSED: rdData_d = stamp_q;
                imuaux_pkg::OFS_UPDATE_COUNT: rdData_d = count_q;
                default:
                begin
                    for (int i = 0; i < imuaux_pkg::AXES; i++)
                    begin
                        if (regAddr == 7'(imuaux_pkg::OFS_ANGLE_BASE + 7'(i) * imuaux_pkg::OFS_ANGLE_STRIDE))
                        begin
                            rdData_d = angle[i][15:0];
                        end
                        if (regAddr == 7'(imuaux_pkg::OFS_ANGLE_BASE + 7'(i) * imuaux_pkg::OFS_ANGLE_STRIDE
                            + imuaux_pkg::OFS_ANGLE_HIGH))
                        begin
                            rdData_d = angle[i][31:16];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sampleCount_q <= 16'h0000;
            temp_q <= imuaux_pkg::WORD_ZERO;
            stamp_q <= imuaux_pkg::WORD_ZERO;
            count_q <= imuaux_pkg::COUNT_RESET;
            prescale_q <= 32'h0000_0000;
            elapsed_q <= 16'h0000;
            syncPrev_q <= 1'b0;
            update_q <= 1'b0;
            rdData_q <= imuaux_pkg::WORD_ZERO;
            ack_q <= 1'b0;
        end
        else
        begin
            sampleCount_q <= sampleCount_d;
            temp_q <= temp_d;
            stamp_q <= stamp_d;
            count_q <= count_d;
            prescale_q <= prescale_d;
            elapsed_q <= elapsed_d;
            syncPrev_q <= syncPin;
            update_q <= lastSample;
            rdData_q <= rdData_d;
            // Writes ack like reads so the host never hangs; contents stay put
            ack_q <= regRd || regWr;
        end
    end

    assign regRdData = rdData_q;
    assign regAck = ack_q;
    assign dataUpdate = update_q;

endmodule

/* pkg/imuaux_pkg.sv */
// Constants and types for the auxiliary output and delta angle logic
package imuaux_pkg;

    // Register byte offsets
    localparam logic [6:0] OFS_DIE_HEAT = 7'h1C;
    localparam logic [6:0] OFS_SYNC_ELAPSED = 7'h1E;
    localparam logic [6:0] OFS_UPDATE_COUNT = 7'h22;
    localparam logic [6:0] OFS_ANGLE_BASE = 7'h24;
    localparam logic [6:0] OFS_ANGLE_STRIDE = 7'h04;
    localparam logic [6:0] OFS_ANGLE_HIGH = 7'h02;
    localparam int AXES = 3;

    // Reset values and saturation limit
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] WORD_ZERO = 16'h0000;

    // Sync mode field, bits 4 to 2 of misc_control
    localparam int SYNC_MODE_LSB = 2;
    localparam int SYNC_MODE_MSB = 4;
    localparam logic [2:0] SYNC_MODE_SCALED = 3'h2;

    // Timing: clock period and time stamp resolution
    localparam int CLK_PERIOD_PS = 5000;
    localparam int STAMP_LSB_PS = 49020000;
    localparam int STAMP_LSB_CYCLES = STAMP_LSB_PS / CLK_PERIOD_PS;

    // Integration: nominal rate and range variants
    localparam longint SAMPLE_RATE_SPS = 2000;
    localparam longint RANGE_360 = 360;
    localparam longint RANGE_720 = 720;
    localparam longint RANGE_2160 = 2160;
    // Rate input LSB is 2^-16 deg/s; output LSB is range/2^31 deg.
    // Gain = 2^47 / (2*fs*range), applied as (sum*gain) >> 32.
    localparam longint GAIN_NUM = 64'h0000_8000_0000_0000;
    localparam int GAIN_SHIFT = 32;
    localparam longint GAIN_360 = GAIN_NUM / (2 * SAMPLE_RATE_SPS * RANGE_360);
    localparam longint GAIN_720 = GAIN_NUM / (2 * SAMPLE_RATE_SPS * RANGE_720);
    localparam longint GAIN_2160 = GAIN_NUM / (2 * SAMPLE_RATE_SPS * RANGE_2160);

    typedef enum logic [1:0]
    {
        RANGE_SEL_360 = 2'b00,
        RANGE_SEL_720 = 2'b01,
        RANGE_SEL_2160 = 2'b10
    } imuaux_range_type;

endpackage

/* pkg/imuaux_axis_if.sv */
// Carrier between the top and one axis integrator
`timescale 1ns/1ps
interface imuaux_axis_if;
    logic sampleValid;
    logic lastSample;
    logic [31:0] rateIn;
    logic [63:0] gain;
    logic [31:0] angleOut;

    modport ctrl
    (
        output sampleValid,
        output lastSample,
        output rateIn,
        output gain,
        input angleOut
    );

    modport integ
    (
        input sampleValid,
        input lastSample,
        input rateIn,
        input gain,
        output angleOut
    );
endinterface

/* hw/imuaux_integrator.sv */
// Per-axis trapezoidal delta angle integrator
`timescale 1ns/1ps
module imuaux_integrator
(
    input wire logic clk,
    input wire logic rst_n,
    imuaux_axis_if.integ axis
);

    logic [31:0] prevRate_q, prevRate_d;
    logic [47:0] acc_q, acc_d;
    logic [31:0] angle_q, angle_d;
    logic [47:0] pairSum;
    logic [47:0] total;
    logic [111:0] product;

    // Pair of consecutive samples, sign extended
    assign pairSum = {{16{axis.rateIn[31]}}, axis.rateIn} + {{16{prevRate_q[31]}}, prevRate_q};
    assign total = acc_q + pairSum;
    // Wide product avoids overflow on long decimation periods
    assign product = $signed(total) * $signed({1'b0, axis.gain});

    // Next accumulator, previous sample and output word
    always_comb
    begin
        prevRate_d = prevRate_q;
        acc_d = acc_q;
        angle_d = angle_q;
        if (axis.sampleValid)
        begin
            prevRate_d = axis.rateIn;
            if (axis.lastSample)
            begin
                // Period ends: scale and restart, 32-bit result wraps like the sum
                angle_d = product[imuaux_pkg::GAIN_SHIFT +: 32];
                acc_d = 48'h0000_0000_0000;
            end
            else
            begin
                acc_d = total;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            prevRate_q <= 32'h0000_0000;
            acc_q <= 48'h0000_0000_0000;
            angle_q <= 32'h0000_0000;
        end
        else
        begin
            prevRate_q <= prevRate_d;
            acc_q <= acc_d;
            angle_q <= angle_d;
        end
    end

    assign axis.angleOut = angle_q;

endmodule

/* tb/imuaux_outputs_checker.sv */
// Port-level assertions for the output register block
`timescale 1ns/1ps
module imuaux_outputs_checker
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sampleStrobe,
    input wire logic [15:0] decimationDivisor,
    input wire logic regRd,
    input wire logic regWr,
    input wire logic [6:0] regAddr,
    input wire logic [15:0] regRdData,
    input wire logic regAck,
    input wire logic dataUpdate
);
    logic [15:0] updCnt_q;
    logic [15:0] updCnt_d;
    wire rdOnly = regRd && !regWr;
    // Shadow of the update count; wraps at 16 bits like the device
    always_comb updCnt_d = updCnt_q + {15'h0000, dataUpdate};
    always_ff @(posedge clk) updCnt_q <= rst_n ? updCnt_d : 16'h0000;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_ack; (regRd || regWr) |=> regAck; endproperty
    property p_noAck; !(regRd || regWr) |=> !regAck; endproperty
    property p_hold; !rdOnly |=> $stable(regRdData); endproperty
    property p_cnt; rdOnly && regAddr == 7'h22 |=> regRdData == updCnt_q; endproperty
    property p_unmap; rdOnly && regAddr == 7'h30 |=> regRdData == 16'h0000; endproperty
    property p_upd; sampleStrobe && decimationDivisor == 16'h0000 |=> dataUpdate; endproperty
    property p_noUpd; !sampleStrobe |=> !dataUpdate; endproperty
    // Two back-to-back samples with divisor one give exactly one update
    property p_div1; (sampleStrobe && decimationDivisor == 16'h0001) [*2] |=> dataUpdate != $past(dataUpdate);
    endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    a_noAck: assert property (p_noAck) else $error("stray ack");
    a_hold: assert property (p_hold) else $error("read data moved");
    a_cnt: assert property (p_cnt) else $error("count wrong");
    a_unmap: assert property (p_unmap) else $error("unmapped not zero");
    a_upd: assert property (p_upd) else $error("update missing");
    a_noUpd: assert property (p_noUpd) else $error("stray update");
    a_div1: assert property (p_div1) else $error("period length wrong");
    c_upd: cover property (dataUpdate);
    c_max: cover property (rdOnly && regAddr == 7'h22 ##1 regRdData == 16'hFFFF);
    c_wr: cover property (regWr ##1 regAck);
endmodule

/* tb/imuaux_host_model.sv */
// Host side model: issues register reads and writes
`timescale 1ns/1ps
module imuaux_host_model
(
    input wire logic clk,
    input wire logic [15:0] regRdData,
    input wire logic regAck,
    output logic regRd,
    output logic regWr,
    output logic [6:0] regAddr,
    output logic ackSeen
);
    // Idle bus at time zero
    initial
    begin
        regRd = 1'b0;
        regWr = 1'b0;
        regAddr = 7'h00;
        ackSeen = 1'b0;
    end
    // One-cycle request; answer taken one edge later
    task automatic acc(input logic wr, input logic [6:0] a, output logic [15:0] d);
        @(posedge clk);
        regRd <= !wr;
        regWr <= wr;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        regWr <= 1'b0;
        @(posedge clk);
        ackSeen = regAck;
        d = regRdData;
    endtask
endmodule

/* tb/imuaux_outputs_test.sv */
// Random and corner tests of the output register block
`timescale 1ns/1ps
module imuaux_outputs_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sampleStrobe = 1'b0;
    logic [15:0] tempRaw = 16'h0000;
    logic [95:0] gyroRate = 96'h0;
    logic syncPin = 1'b0;
    logic [15:0] miscControl = 16'h0000;
    logic [15:0] decimationDivisor = 16'h0000;
    logic regRd, regWr, regAck, dataUpdate, ackSeen;
    logic [6:0] regAddr;
    logic [15:0] regRdData, lo, hi, d;
    logic [15:0] rdWide, loW;
    logic [15:0] expCount = 16'h0000;
    longint sum[3];
    longint prev[3] = '{0, 0, 0};
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;
    int k;
    imuaux_outputs #(.STAMP_CYCLES(4)) DUT (.clk, .rst_n, .sampleStrobe, .tempRaw, .gyroRate, .syncPin,
        .miscControl, .decimationDivisor, .regRd, .regWr, .regAddr, .regRdData, .regAck, .dataUpdate);
    imuaux_host_model host (.clk, .regRdData, .regAck, .regRd, .regWr, .regAddr, .ackSeen);
    // Widest range variant on the same stimulus; only its read data is compared
    imuaux_outputs #(.STAMP_CYCLES(4), .RANGE_SEL(imuaux_pkg::RANGE_SEL_2160)) DUT2 (.clk, .rst_n, .sampleStrobe,
        .tempRaw, .gyroRate, .syncPin, .miscControl, .decimationDivisor, .regRd, .regWr, .regAddr,
        .regRdData(rdWide), .regAck(), .dataUpdate());
    initial forever #2.5 clk = ~clk;
    // Hang guard, well above the longest test
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            errors++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Expected angle from the trapezoid sum at the nominal rate
    function automatic logic [31:0] angleOf(longint s, longint g);
        return 32'((s * g) >>> imuaux_pkg::GAIN_SHIFT);
    endfunction
    // n back-to-back samples with random rates, tracking the sum
    task automatic period(input int n);
        longint w;
        foreach (sum[a]) sum[a] = 0;
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk);
            sampleStrobe <= 1'b1;
            for (int a = 0; a < 3; a++)
            begin
                w = $signed($urandom) >>> 8;
                gyroRate[a*32 +: 32] <= w[31:0];
                sum[a] += w + prev[a];
                prev[a] = w;
            end
        end
        @(posedge clk);
        sampleStrobe <= 1'b0;
        expCount++;
    endtask
    initial
    begin
        k = $urandom(32'h3287);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (k = 28; k <= 48; k += 2)
        begin
            host.acc(1'b0, 7'(k), d);
            chk(d, 0);
        end
        $display("reset test done");
        // Periods of 1 to 4 samples, negative temperature first
        for (int p = 0; p < 6; p++)
        begin
            decimationDivisor <= 16'(p % 4);
            tempRaw <= p == 0 ? 16'hFE70 : 16'($urandom);
            period(p % 4 + 1);
            host.acc(1'b0, 7'h1C, d);
            chk(d, tempRaw);
            host.acc(1'b0, 7'h1E, d);
            chk(d, 0);
            host.acc(1'b0, 7'h22, d);
            chk(d, expCount);
            for (int a = 0; a < 3; a++)
            begin
                host.acc(1'b0, 7'(36 + 4 * a), lo);
                loW = rdWide;
                host.acc(1'b0, 7'(38 + 4 * a), hi);
                chk({hi, lo}, angleOf(sum[a], imuaux_pkg::GAIN_360));
                chk({rdWide, loW}, angleOf(sum[a], imuaux_pkg::GAIN_2160));
            end
        end
        $display("integration test done");
        host.acc(1'b1, 7'h22, d);
        chk(ackSeen, 1'b1);
        host.acc(1'b1, 7'h1C, d);
        chk(ackSeen, 1'b1);
        host.acc(1'b0, 7'h22, d);
        chk(d, expCount);
        host.acc(1'b0, 7'h1C, d);
        chk(d, tempRaw);
        $display("write test done");
        // Scaled sync: about ten stamp counts after the pin edge
        miscControl <= 16'h0008;
        decimationDivisor <= 16'h0000;
        @(posedge clk);
        syncPin <= 1'b1;
        repeat (41) @(posedge clk);
        period(1);
        host.acc(1'b0, 7'h1E, d);
        chk(d >= 9 && d <= 11, 1);
        $display("stamp test done");
        // Reset command mid-run must restart the counter and clear the high word of the first axis angle
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        expCount = 16'h0000;
        prev = '{0, 0, 0};
        host.acc(1'b0, 7'h22, d);
        chk(d, expCount);
        host.acc(1'b0, 7'h26, d);
        chk(d, 0);
        $display("mid reset test done");
        // Run the counter up to its top value and across the wrap
        gyroRate <= 96'h0;
        k = 16'hFFFF - expCount;
        @(posedge clk);
        sampleStrobe <= 1'b1;
        repeat (k) @(posedge clk);
        sampleStrobe <= 1'b0;
        expCount = 16'hFFFF;
        host.acc(1'b0, 7'h22, d);
        chk(d, 16'hFFFF);
        period(1);
        host.acc(1'b0, 7'h22, d);
        chk(d, 16'h0000);
        $display("wrap test done");
        report_and_stop();
    end
endmodule
bind imuaux_outputs imuaux_outputs_checker chk_i (.clk, .rst_n, .sampleStrobe, .decimationDivisor, .regRd,
    .regWr, .regAddr, .regRdData, .regAck, .dataUpdate);
